/* File: core/sdt_consts.svh */
`ifndef SDT_CONSTS_SVH
`define SDT_CONSTS_SVH

// ****************************************************************
// Register word indices; the byte address is four times the index.
// ****************************************************************
`define SDT_IDX_CLOCK_SOURCE 6'h00
`define SDT_IDX_OUTPUT_ENABLE 6'h01
`define SDT_IDX_OUTPUT_LEVEL 6'h02
`define SDT_IDX_OPERATING_MODE 6'h04
`define SDT_IDX_UNDERFLOW_LEVEL 6'h06
`define SDT_IDX_COMPARE_LEVEL 6'h07
`define SDT_IDX_COMMAND 6'h08
`define SDT_IDX_FLAGS 6'h0C
`define SDT_IDX_LOW_COUNT 6'h20
`define SDT_IDX_HIGH_COUNT 6'h21

// ****************************************************************
// Field positions.
// ****************************************************************
`define SDT_CMD_CODE_LSB 2
`define SDT_CMD_TARGET_LSB 0
`define SDT_FLAG_LOW_UNF 0
`define SDT_FLAG_HIGH_UNF 1
`define SDT_FLAG_CMP_LSB 4
`define SDT_HIGH_HALF_LSB 4

// ****************************************************************
// Reset values.
// ****************************************************************
`define SDT_RST_BYTE 8'h00
`define SDT_RST_NIBBLE 4'h0
`define SDT_RST_PAIR 2'h0
`define SDT_RST_WORD 32'h0000_0000

`endif

/* File: core/sdt_pkg.sv */
package sdt_pkg;

  // ****************************************************************
  // Operating modes, commands and clock sources.
  // ****************************************************************
  typedef enum logic [1:0] {
    SDT_MODE_NORMAL = 2'h0,
    SDT_MODE_UPPER_CLEAR = 2'h1,
    SDT_MODE_DUAL_EIGHT_BIT = 2'h2,
    SDT_MODE_RESERVED = 2'h3
  } sdt_mode_type;

  typedef enum logic [1:0] {
    SDT_CMD_NONE = 2'h0,
    SDT_CMD_RESERVED = 2'h1,
    SDT_CMD_RESTART = 2'h2,
    SDT_CMD_HARD_RESET = 2'h3
  } sdt_cmd_type;

  typedef enum logic [3:0] {
    SDT_CLK_OFF = 4'h0,
    SDT_CLK_DIV1 = 4'h1,
    SDT_CLK_DIV2 = 4'h2,
    SDT_CLK_DIV4 = 4'h3,
    SDT_CLK_DIV8 = 4'h4,
    SDT_CLK_DIV64 = 4'h5,
    SDT_CLK_DIV256 = 4'h6,
    SDT_CLK_DIV1024 = 4'h7
  } sdt_clock_type;

endpackage : sdt_pkg

/* File: core/sdt_ctrl.sv */
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ns
`include "sdt_consts.svh"
module sdt_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] event_channel_clock_i,
  input wire logic [7:0] low_period_i,
  input wire logic [7:0] high_period_i,
  input wire logic [31:0] low_compare_i,
  input wire logic [31:0] high_compare_i,
  input wire logic [7:0] vector_ack_i,
  output logic [7:0] pin_out_o,
  output logic [7:0] pin_override_o,
  output logic [1:0] low_underflow_irq_o,
  output logic [1:0] high_underflow_irq_o,
  output logic [7:0] compare_irq_o,
  output logic [1:0] underflow_event_o,
  output logic [3:0] compare_event_o
);

  // ****************************************************************
  // Decoding helpers.
  // ****************************************************************
  function automatic logic reg_hit(input logic [7:0] adr, input logic [5:0] want);
    return adr[7:2] == want;
  endfunction : reg_hit
  function automatic logic sel_tick(input logic [3:0] src, input logic [9:0] pre,
                                    input logic [7:0] ev);
    logic t;
    t = 1'b0;
    case (src)
      sdt_pkg::SDT_CLK_OFF: t = 1'b0;
      sdt_pkg::SDT_CLK_DIV1: t = 1'b1;
      sdt_pkg::SDT_CLK_DIV2: t = pre[0];
      sdt_pkg::SDT_CLK_DIV4: t = &pre[1:0];
      sdt_pkg::SDT_CLK_DIV8: t = &pre[2:0];
      sdt_pkg::SDT_CLK_DIV64: t = &pre[5:0];
      sdt_pkg::SDT_CLK_DIV256: t = &pre[7:0];
      sdt_pkg::SDT_CLK_DIV1024: t = &pre[9:0];
      default: t = ev[src[2:0]];
    endcase
    return t;
  endfunction : sel_tick

  // ****************************************************************
  // State.
  // ****************************************************************
  logic [3:0] clock_source_field, underflow_level, compare_match_flag, cmp_hit_low, cmp_hit_high;
  logic [7:0] output_enable, wg_level, compare_irq_level, low_count_value, high_count_value;
  logic [7:0] next_low, next_high;
  logic [1:0] operating_mode_field, command_target, cmd_code, cmd_tgt;
  logic [9:0] prescale;
  logic [31:0] rd_data;
  logic low_underflow_flag, high_underflow_flag, low_bottom, high_bottom, count_tick, is_off;
  logic wb_req, wr_commit, cmd_wr, restart_low, restart_high, hard_low, hard_high, hard_all;
  logic lvl_wr, flag_wr;

  // ****************************************************************
  // Bus slave.
  // ****************************************************************
  assign wb_req = wb_cyc_i & wb_stb_i;
  assign wr_commit = wb_req & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign lvl_wr = wr_commit & reg_hit(wb_adr_i, `SDT_IDX_OUTPUT_LEVEL);
  assign flag_wr = wr_commit & reg_hit(wb_adr_i, `SDT_IDX_FLAGS);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
    end
  end

  always_comb begin
    rd_data = `SDT_RST_WORD;
    case (wb_adr_i[7:2])
      `SDT_IDX_CLOCK_SOURCE: rd_data[3:0] = clock_source_field;
      `SDT_IDX_OUTPUT_ENABLE: rd_data[7:0] = output_enable;
      `SDT_IDX_OUTPUT_LEVEL: rd_data[7:0] = wg_level;
      `SDT_IDX_OPERATING_MODE: rd_data[1:0] = operating_mode_field;
      `SDT_IDX_UNDERFLOW_LEVEL: rd_data[3:0] = underflow_level;
      `SDT_IDX_COMPARE_LEVEL: rd_data[7:0] = compare_irq_level;
      `SDT_IDX_COMMAND: rd_data[1:0] = command_target;
      `SDT_IDX_FLAGS: rd_data[7:0] = {compare_match_flag, 2'h0, high_underflow_flag,
                                      low_underflow_flag};
      `SDT_IDX_LOW_COUNT: rd_data[7:0] = low_count_value;
      `SDT_IDX_HIGH_COUNT: rd_data[7:0] = high_count_value;
      default: rd_data = `SDT_RST_WORD;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= `SDT_RST_WORD;
    end else if (wb_req & ~wb_ack_o & ~wb_we_i) begin
      wb_dat_o <= rd_data;
    end
  end

  // ****************************************************************
  // Commands.
  // ****************************************************************
  assign cmd_wr = wr_commit & reg_hit(wb_adr_i, `SDT_IDX_COMMAND);
  assign cmd_code = wb_dat_i[`SDT_CMD_CODE_LSB +: 2];
  assign cmd_tgt = wb_dat_i[`SDT_CMD_TARGET_LSB +: 2];
  assign is_off = clock_source_field == sdt_pkg::SDT_CLK_OFF;
  assign restart_low = cmd_wr & (cmd_code == sdt_pkg::SDT_CMD_RESTART) & cmd_tgt[0];
  assign restart_high = cmd_wr & (cmd_code == sdt_pkg::SDT_CMD_RESTART) & cmd_tgt[1];
  assign hard_low = cmd_wr & (cmd_code == sdt_pkg::SDT_CMD_HARD_RESET) & cmd_tgt[0] & is_off;
  assign hard_high = cmd_wr & (cmd_code == sdt_pkg::SDT_CMD_HARD_RESET) & cmd_tgt[1] & is_off;
  assign hard_all = hard_low & hard_high;

  // ****************************************************************
  // Control registers.
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i || hard_all) begin
      clock_source_field <= `SDT_RST_NIBBLE;
      operating_mode_field <= `SDT_RST_PAIR;
      underflow_level <= `SDT_RST_NIBBLE;
      compare_irq_level <= `SDT_RST_BYTE;
      command_target <= `SDT_RST_PAIR;
    end else if (wr_commit) begin
      if (reg_hit(wb_adr_i, `SDT_IDX_CLOCK_SOURCE)) begin
        clock_source_field <= wb_dat_i[3:0];
      end
      if (reg_hit(wb_adr_i, `SDT_IDX_OPERATING_MODE)) begin
        operating_mode_field <= wb_dat_i[1:0];
      end
      if (reg_hit(wb_adr_i, `SDT_IDX_UNDERFLOW_LEVEL)) begin
        underflow_level <= wb_dat_i[3:0];
      end
      if (reg_hit(wb_adr_i, `SDT_IDX_COMPARE_LEVEL)) begin
        compare_irq_level <= wb_dat_i[7:0];
      end
      if (cmd_wr) begin
        command_target <= cmd_tgt;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      output_enable <= `SDT_RST_BYTE;
    end else begin
      if (hard_low) begin
        output_enable[3:0] <= `SDT_RST_NIBBLE;
      end else if (wr_commit && reg_hit(wb_adr_i, `SDT_IDX_OUTPUT_ENABLE)) begin
        output_enable[3:0] <= wb_dat_i[3:0];
      end
      if (hard_high) begin
        output_enable[7:4] <= `SDT_RST_NIBBLE;
      end else if (wr_commit && reg_hit(wb_adr_i, `SDT_IDX_OUTPUT_ENABLE)) begin
        output_enable[7:4] <= wb_dat_i[7:4];
      end
    end
  end

  // ****************************************************************
  // Clock source.
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prescale <= 10'h000;
    end else begin
      prescale <= prescale + 10'h001;
    end
  end

  assign count_tick = sel_tick(clock_source_field, prescale, event_channel_clock_i);

  // ****************************************************************
  // Counting core.
  // ****************************************************************
  always_comb begin
    next_low = low_count_value;
    next_high = high_count_value;
    low_bottom = 1'b0;
    high_bottom = 1'b0;
    if (count_tick) begin
      case (operating_mode_field)
        sdt_pkg::SDT_MODE_DUAL_EIGHT_BIT: begin
          low_bottom = low_count_value == 8'h00;
          high_bottom = high_count_value == 8'h00;
          next_low = low_bottom ? low_period_i : low_count_value - 8'h01;
          next_high = high_bottom ? high_period_i : high_count_value - 8'h01;
        end
        sdt_pkg::SDT_MODE_UPPER_CLEAR: begin
          low_bottom = low_count_value == 8'h00;
          next_low = low_bottom ? low_period_i : low_count_value - 8'h01;
          next_high = 8'h00;
        end
        default: begin
          low_bottom = {high_count_value, low_count_value} == 16'h0000;
          {next_high, next_low} = low_bottom ? {high_period_i, low_period_i} :
                                  {high_count_value, low_count_value} - 16'h0001;
        end
      endcase
    end
    if (restart_low || hard_low) begin
      next_low = 8'h00;
    end
    if (restart_high || hard_high) begin
      next_high = 8'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_count_value <= `SDT_RST_BYTE;
      high_count_value <= `SDT_RST_BYTE;
    end else begin
      low_count_value <= next_low;
      high_count_value <= next_high;
    end
  end

  // ****************************************************************
  // Compare channels.
  // ****************************************************************
  for (genvar ch = 0; ch < 4; ch++) begin : g_cmp
    assign cmp_hit_low[ch] = count_tick & (low_count_value == low_compare_i[ch*8 +: 8]);
    assign cmp_hit_high[ch] = count_tick & (high_count_value == high_compare_i[ch*8 +: 8]);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wg_level <= `SDT_RST_BYTE;
    end else begin
      for (int ch = 0; ch < 4; ch++) begin
        if (restart_low || hard_low) begin
          wg_level[ch] <= 1'b0;
        end else if (is_off && lvl_wr) begin
          wg_level[ch] <= wb_dat_i[ch];
        end else if (cmp_hit_low[ch]) begin
          wg_level[ch] <= 1'b1;
        end else if (low_bottom) begin
          wg_level[ch] <= 1'b0;
        end
        if (restart_high || hard_high) begin
          wg_level[ch + 4] <= 1'b0;
        end else if (is_off && lvl_wr) begin
          wg_level[ch + 4] <= wb_dat_i[ch + 4];
        end else if (cmp_hit_high[ch]) begin
          wg_level[ch + 4] <= 1'b1;
        end else if (high_bottom || low_bottom) begin
          wg_level[ch + 4] <= 1'b0;
        end
      end
    end
  end
  assign pin_out_o = wg_level;
  assign pin_override_o = output_enable;

  // ****************************************************************
  // Flags, set wins over clear; a hard reset clear wins over set.
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_match_flag <= `SDT_RST_NIBBLE;
      low_underflow_flag <= 1'b0;
      high_underflow_flag <= 1'b0;
    end else begin
      for (int ch = 0; ch < 4; ch++) begin
        if (hard_low) begin
          compare_match_flag[ch] <= 1'b0;
        end else if (cmp_hit_low[ch]) begin
          compare_match_flag[ch] <= 1'b1;
        end else if ((flag_wr && wb_dat_i[`SDT_FLAG_CMP_LSB + ch]) ||
                     vector_ack_i[`SDT_FLAG_CMP_LSB + ch]) begin
          compare_match_flag[ch] <= 1'b0;
        end
      end
      if (hard_low) begin
        low_underflow_flag <= 1'b0;
      end else if (low_bottom) begin
        low_underflow_flag <= 1'b1;
      end else if ((flag_wr && wb_dat_i[`SDT_FLAG_LOW_UNF]) ||
                   vector_ack_i[`SDT_FLAG_LOW_UNF]) begin
        low_underflow_flag <= 1'b0;
      end
      if (hard_high) begin
        high_underflow_flag <= 1'b0;
      end else if (high_bottom) begin
        high_underflow_flag <= 1'b1;
      end else if ((flag_wr && wb_dat_i[`SDT_FLAG_HIGH_UNF]) ||
                   vector_ack_i[`SDT_FLAG_HIGH_UNF]) begin
        high_underflow_flag <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Interrupt requests and events.
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_underflow_irq_o <= `SDT_RST_PAIR;
      high_underflow_irq_o <= `SDT_RST_PAIR;
      compare_irq_o <= `SDT_RST_BYTE;
    end else begin
      low_underflow_irq_o <= low_underflow_flag ? underflow_level[1:0] : 2'h0;
      high_underflow_irq_o <= high_underflow_flag ? underflow_level[3:2] : 2'h0;
      for (int ch = 0; ch < 4; ch++) begin
        compare_irq_o[ch*2 +: 2] <= compare_match_flag[ch] ?
                                    compare_irq_level[ch*2 +: 2] : 2'h0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      underflow_event_o <= `SDT_RST_PAIR;
      compare_event_o <= `SDT_RST_NIBBLE;
    end else begin
      underflow_event_o <= {high_bottom, low_bottom};
      compare_event_o <= cmp_hit_low;
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_off_no_tick: assert property (
    clock_source_field == 4'h0 |-> !count_tick)
    else $error("Counter ticked while clock source is off.");
  chk_div2_rate: assert property (
    (clock_source_field == 4'h2 && count_tick) ##1 (clock_source_field == 4'h2) |-> !count_tick)
    else $error("Divide by two tick came in back to back cycles.");
  chk_event_clock: assert property (
    clock_source_field[3] |-> count_tick == event_channel_clock_i[clock_source_field[2:0]])
    else $error("Event channel clock not followed.");
  chk_enable_write: assert property (
    wr_commit && reg_hit(wb_adr_i, 6'h01) && !cmd_wr |=> pin_override_o == $past(wb_dat_i[7:0]))
    else $error("Override enables did not take the written value.");
  chk_level_stopped: assert property (
    lvl_wr && is_off |=> pin_out_o == $past(wb_dat_i[7:0]))
    else $error("Output level write while stopped not applied.");
  chk_upper_clear: assert property (
    operating_mode_field == 2'h1 && count_tick |=> high_count_value == 8'h00)
    else $error("Upper byte not cleared after a tick.");
  chk_cmd_reads_zero: assert property (
    wb_ack_o && !wb_we_i && reg_hit(wb_adr_i, 6'h08) |-> wb_dat_o[3:2] == 2'h0)
    else $error("Command code read back nonzero.");
  chk_restart_low: assert property (
    restart_low |=> low_count_value == 8'h00 && wg_level[3:0] == 4'h0)
    else $error("Restart left low counter or outputs nonzero.");
  chk_reset_ignored: assert property (
    cmd_wr && cmd_code == 2'h3 && !is_off
    |=> $stable(clock_source_field) && $stable(output_enable) && $stable(compare_irq_level))
    else $error("Hard reset acted while running.");
  chk_cmp_flag_set: assert property (
    count_tick && low_count_value == low_compare_i[7:0] |=> compare_match_flag[0])
    else $error("Compare flag A not set on match.");
  chk_flag_w0_keep: assert property (
    compare_match_flag[1] && !vector_ack_i[5] && !hard_low && !(flag_wr && wb_dat_i[5])
    |=> compare_match_flag[1])
    else $error("Compare flag B dropped without a clear.");
  chk_unf_irq: assert property (
    low_underflow_flag && underflow_level[1:0] != 2'h0 ##1 $stable(underflow_level)
    |-> low_underflow_irq_o == $past(underflow_level[1:0]))
    else $error("Low underflow request not at its level.");
  cov_split_underflow: cover property (
    operating_mode_field == 2'h2 && high_bottom ##[1:20] low_bottom);
  cov_restart_both: cover property (restart_low && restart_high);
  cov_hard_reset: cover property (hard_all);
endmodule : sdt_ctrl

/* File: testbench/sdt_partner.sv */
`timescale 1ns/1ns

// ****************************************************************
// Event system and interrupt controller seen from the timer.
// ****************************************************************
module sdt_partner (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] ev_req_i,
  input wire logic ack_en_i,
  input wire logic [1:0] low_irq_i,
  input wire logic [1:0] high_irq_i,
  input wire logic [7:0] cmp_irq_i,
  output logic [7:0] event_o,
  output logic [7:0] vector_ack_o
);
  logic busy;

  // Event channels pulse one cycle when the bench asks for them.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      event_o <= 8'h00;
    end else begin
      event_o <= ev_req_i;
    end
  end

  // Every pending request with a nonzero level gets its vector run.
  always_ff @(posedge clk_i) begin
    if (rst_i || !ack_en_i || busy) begin
      vector_ack_o <= 8'h00;
      busy <= 1'b0;
    end else begin
      vector_ack_o <= {|cmp_irq_i[7:6], |cmp_irq_i[5:4], |cmp_irq_i[3:2], |cmp_irq_i[1:0],
                       2'h0, |high_irq_i, |low_irq_i};
      busy <= 1'b1;
    end
  end
endmodule : sdt_partner

/* File: testbench/split_dual_byte_timer_control_tb.sv */
`timescale 1ns/1ns
`include "sdt_consts.svh"

module split_dual_byte_timer_control_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic ack_en = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [7:0] ev_req = 8'h00;
  logic [7:0] lper = 8'h03;
  logic [7:0] hper = 8'h05;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] lcmp = 32'h0101_0101;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [7:0] evc, vack, pin_out_o, pin_override_o, compare_irq_o, v, r, n;
  logic [1:0] low_irq, high_irq, uev;
  logic [3:0] cev, hit3;
  logic [7:0] q[$];
  int num_errors = 0;
  int tests_run = 0;

  always #50 clk_i = ~clk_i;

  sdt_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .event_channel_clock_i(evc), .low_period_i(lper),
    .high_period_i(hper), .low_compare_i(lcmp), .high_compare_i(lcmp),
    .vector_ack_i(vack), .pin_out_o(pin_out_o), .pin_override_o(pin_override_o),
    .low_underflow_irq_o(low_irq), .high_underflow_irq_o(high_irq),
    .compare_irq_o(compare_irq_o), .underflow_event_o(uev), .compare_event_o(cev));

  sdt_partner part_u (.clk_i(clk_i), .rst_i(rst_i), .ev_req_i(ev_req), .ack_en_i(ack_en),
    .low_irq_i(low_irq), .high_irq_i(high_irq), .cmp_irq_i(compare_irq_o),
    .event_o(evc), .vector_ack_o(vack));

  // ****************************************************************
  // Compare, bus and closing tasks.
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chk_pins(input string nm, input logic [7:0] e, input logic [7:0] g);
    chk(nm, {24'h000000, e}, {24'h000000, g});
  endtask : chk_pins

  task automatic chk_irq(input string nm, input logic [11:0] e, input logic [11:0] g);
    chk(nm, {20'h00000, e}, {20'h00000, g});
  endtask : chk_irq

  task automatic wbt(input logic w, input logic [5:0] i, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    dat <= {24'h000000, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wbt

  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    wbt(1'b1, i, d);
  endtask : wr

  task automatic rd(input logic [5:0] i, input logic [7:0] e);
    q.push_back(e);
    wbt(1'b0, i, 8'h00);
  endtask : rd

  task automatic pulse(input logic [2:0] k, input logic [5:0] e);
    @(posedge clk_i);
    ev_req <= 8'h01 << k;
    @(posedge clk_i);
    ev_req <= 8'h00;
    repeat (2) @(posedge clk_i);
    chk("event outputs", {26'h0, e}, {26'h0, cev, uev});
    @(posedge clk_i);
  endtask : pulse

  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  // Read data is compared against the oldest note at each read ack.
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && cyc && !we) begin
      chk("read data", {24'h000000, q.pop_front()}, wb_dat_o);
    end
  end

  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    final_report();
  end

  // ****************************************************************
  // Test sequence.
  // ****************************************************************
  initial begin
    void'($urandom(32'hE225));
    v = 8'($urandom);
    r = 8'($urandom) | 8'h55;
    n = 8'($urandom % 8);
    lcmp <= {8'(1 + $urandom % 3), 8'(1 + $urandom % 3), 8'(1 + $urandom % 3), 8'h02};
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`SDT_IDX_CLOCK_SOURCE, 8'h00);
    rd(`SDT_IDX_OUTPUT_ENABLE, 8'h00);
    rd(`SDT_IDX_FLAGS, 8'h00);
    rd(`SDT_IDX_COMMAND, 8'h00);
    rd(6'h3F, 8'h00);
    $display("test reset done");
    wr(`SDT_IDX_OUTPUT_ENABLE, v);
    rd(`SDT_IDX_OUTPUT_ENABLE, v);
    repeat (2) @(posedge clk_i);
    chk_pins("pin_override", v, pin_override_o);
    wr(`SDT_IDX_COMMAND, 8'h0B);
    rd(`SDT_IDX_COMMAND, 8'h03);
    wr(`SDT_IDX_OPERATING_MODE, 8'h02);
    wr(`SDT_IDX_UNDERFLOW_LEVEL, 8'h06);
    wr(`SDT_IDX_COMPARE_LEVEL, r);
    rd(`SDT_IDX_UNDERFLOW_LEVEL, 8'h06);
    rd(`SDT_IDX_COMPARE_LEVEL, r);
    $display("test setup done");
    wr(`SDT_IDX_CLOCK_SOURCE, 8'h01);
    repeat (60) @(posedge clk_i);
    wr(`SDT_IDX_CLOCK_SOURCE, 8'h00);
    rd(`SDT_IDX_FLAGS, 8'hF3);
    repeat (2) @(posedge clk_i);
    chk_irq("underflow irq", 12'h006, {8'h00, high_irq, low_irq});
    chk_irq("compare irq", {4'h0, r}, {4'h0, compare_irq_o});
    wr(`SDT_IDX_FLAGS, 8'h10);
    rd(`SDT_IDX_FLAGS, 8'hE3);
    ack_en <= 1'b1;
    repeat (8) @(posedge clk_i);
    ack_en <= 1'b0;
    rd(`SDT_IDX_FLAGS, 8'h00);
    chk_irq("irq idle", 12'h000, {high_irq, low_irq, compare_irq_o});
    $display("test flags done");
    wr(`SDT_IDX_COMMAND, 8'h09);
    rd(`SDT_IDX_LOW_COUNT, 8'h00);
    wr(`SDT_IDX_OUTPUT_LEVEL, v);
    rd(`SDT_IDX_OUTPUT_LEVEL, v);
    chk_pins("pin_out", v, pin_out_o);
    wr(`SDT_IDX_CLOCK_SOURCE, 8'h08);
    wr(`SDT_IDX_OUTPUT_LEVEL, ~v);
    rd(`SDT_IDX_OUTPUT_LEVEL, v);
    wr(`SDT_IDX_COMMAND, 8'h0F);
    rd(`SDT_IDX_COMPARE_LEVEL, r);
    wr(`SDT_IDX_CLOCK_SOURCE, 8'h00);
    wr(`SDT_IDX_COMMAND, 8'h0F);
    rd(`SDT_IDX_COMPARE_LEVEL, 8'h00);
    rd(`SDT_IDX_OUTPUT_ENABLE, 8'h00);
    rd(`SDT_IDX_OPERATING_MODE, 8'h00);
    $display("test commands done");
    wr(`SDT_IDX_OPERATING_MODE, 8'h02);
    wr(`SDT_IDX_CLOCK_SOURCE, 8'h08 | n);
    pulse(3'(n + 1), 6'h00);
    rd(`SDT_IDX_LOW_COUNT, 8'h00);
    pulse(3'(n), 6'h03);
    rd(`SDT_IDX_LOW_COUNT, lper);
    for (int i = 0; i < 4; i++) hit3[i] = lcmp[i*8 +: 8] == 8'h03;
    pulse(3'(n), {hit3, 2'b00});
    wr(`SDT_IDX_OPERATING_MODE, 8'h01);
    wr(`SDT_IDX_CLOCK_SOURCE, 8'h01);
    repeat (20) @(posedge clk_i);
    wr(`SDT_IDX_CLOCK_SOURCE, 8'h00);
    rd(`SDT_IDX_HIGH_COUNT, 8'h00);
    $display("test clocking done");
    final_report();
  end
endmodule : split_dual_byte_timer_control_tb
